// *** estc_top.sv ***
// estc_top: exception syndrome registers and hypervisor trap control.
// assumes a system register port in the core clock domain and a core
// that reports taken exceptions and the current level and world.
`timescale 1ns/1ps
module estc_top
    import estc_pkg::*;
#(
    parameter bit HAS_EL2 = 1'b1
) (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic CLK_EN,
    // system register access
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [2:0] REG_SEL,
    input wire logic [63:0] REG_WDATA,
    output logic [63:0] REG_RDATA,
    // core state
    input wire logic [1:0] CUR_EL,
    input wire logic MONITOR_WORLD_SELECT,
    input wire logic PTR_AUTH_ENABLED,
    input wire logic STAGE1_MMU_ON_BIT,
    input wire logic ERROR_RECORD_SELECT,
    input wire logic [24:0] VIRT_SERR_SYN,
    input wire logic [63:0] CORE_ERR_STATUS,
    input wire logic [63:0] SHARED_ERR_STATUS,
    // exception reporting
    input wire logic EXC_TAKE,
    input wire logic [1:0] EXC_TARGET_EL,
    input wire logic [1:0] EXC_KIND,
    input wire logic [5:0] EXC_CLASS,
    input wire logic EXC_LEN32,
    input wire logic [24:0] EXC_PAYLOAD,
    input wire logic EXC_AET_UNREC,
    // instruction classification for trap checks
    input wire logic INSTR_PTR_AUTH,
    input wire logic INSTR_KEY_ACCESS,
    input wire logic INSTR_ID3_READ,
    input wire logic INSTR_ERET_TO_EL1,
    // trap decisions
    output logic TRAP_TO_EL2,
    output logic [5:0] TRAP_CLASS,
    output logic ILLEGAL_RETURN,
    output logic ROUTE_EL1_TO_EL2,
    output logic EFF_STAGE1_MMU_ON,
    output logic EFF_FIQ_ROUTE_OVERRIDE,
    output logic EFF_IRQ_ROUTE_OVERRIDE,
    output logic EFF_SERROR_ROUTE_OVERRIDE,
    output logic VIRT_IRQ_ENABLE
);
    logic [31:0] syndrome_reg_level1;
    logic [31:0] syndrome_reg_level2;
    logic [31:0] syndrome_reg_level3;
    logic [63:0] hyp_config_reg;
    logic [63:0] rdata;

    wire logic [31:0] syn_word;
    wire logic [63:0] hyp_wr_value;
    wire logic [63:0] hyp_view;
    wire logic hyp_wr;
    wire logic route_gen;
    wire logic nonsecure;
    wire logic at_el0;
    wire logic at_el1;
    wire logic ptr_trap;
    wire logic key_trap;
    wire logic id3_trap;
    wire logic [63:0] err_view;
    wire logic [63:0] next_rdata;

    function automatic logic [63:0] fix_hyp(input logic [63:0] v);
        fix_hyp = (v & ~HC_RSVD0_MASK) | HC_RSVD1_MASK;
    endfunction

    estc_syn_fmt u_fmt (
        .evt_kind(EXC_KIND),
        .evt_class(EXC_CLASS),
        .evt_len32(EXC_LEN32),
        .evt_payload(EXC_PAYLOAD),
        .evt_aet_unrec(EXC_AET_UNREC),
        .virt_serr_syn(VIRT_SERR_SYN),
        .syn_word(syn_word)
    );

    // capture of the syndrome per target level
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            syndrome_reg_level1 <= 32'h0000_0000;
        end else if (CLK_EN) begin
            if (EXC_TAKE && EXC_TARGET_EL == EL1) begin
                syndrome_reg_level1 <= syn_word;
            end else if (REG_WR && REG_SEL == SEL_SYN1) begin
                syndrome_reg_level1 <= REG_WDATA[31:0];
            end
        end
    end

    // level 2/3 and hypervisor config are not reset on purpose; software
    // must initialise them before use
    always_ff @(posedge CORE_CLK) begin
        if (CLK_EN) begin
            if (EXC_TAKE && EXC_TARGET_EL == EL2) begin
                syndrome_reg_level2 <= syn_word;
            end else if (REG_WR && REG_SEL == SEL_SYN2) begin
                syndrome_reg_level2 <= REG_WDATA[31:0];
            end
            if (EXC_TAKE && EXC_TARGET_EL == EL3) begin
                syndrome_reg_level3 <= syn_word;
            end else if (REG_WR && REG_SEL == SEL_SYN3) begin
                syndrome_reg_level3 <= REG_WDATA[31:0];
            end
            if (hyp_wr) begin
                hyp_config_reg <= hyp_wr_value;
            end
        end
    end

    assign hyp_wr = REG_WR && REG_SEL == SEL_HYPCFG && HAS_EL2;
    assign hyp_wr_value = fix_hyp(REG_WDATA);
    assign hyp_view = HAS_EL2 ? fix_hyp(hyp_config_reg)
                              : 64'h0000_0000_0000_0000;

    // routing read straight from the register each cycle, so a write
    // takes effect next cycle with nothing cached to flush
    assign nonsecure = MONITOR_WORLD_SELECT;
    assign route_gen = HAS_EL2 && hyp_view[HC_ROUTE_GEN]
                       && nonsecure;
    assign at_el0 = CUR_EL == EL0;
    assign at_el1 = CUR_EL == EL1;

    // trap bit low selects trapping for pointer auth and key access; the ID3 trap bit high selects trapping
    assign ptr_trap = HAS_EL2 && nonsecure && INSTR_PTR_AUTH &&
        !hyp_view[HC_PTR_AUTH] &&
        ((at_el0 && (!hyp_view[HC_ROUTE_GEN] || !hyp_view[HC_HOST_EXT]))
         || (at_el1 && PTR_AUTH_ENABLED));
    assign key_trap = HAS_EL2 && nonsecure && at_el1 && INSTR_KEY_ACCESS &&
        !hyp_view[HC_KEY_TRAP];
    assign id3_trap = HAS_EL2 && nonsecure && at_el1 && INSTR_ID3_READ &&
        hyp_view[HC_ID3_TRAP];

    assign TRAP_TO_EL2 = ptr_trap || key_trap || id3_trap;
    assign TRAP_CLASS = ptr_trap ? EC_PTR_AUTH :
                        key_trap ? EC_SYSREG :
                        id3_trap ? EC_SYSREG : EC_UNKNOWN;

    assign ROUTE_EL1_TO_EL2 = route_gen;
    assign EFF_STAGE1_MMU_ON = STAGE1_MMU_ON_BIT && !route_gen;
    assign EFF_FIQ_ROUTE_OVERRIDE = hyp_view[HC_FMO] || route_gen;
    assign EFF_IRQ_ROUTE_OVERRIDE = hyp_view[HC_IMO] || route_gen;
    assign EFF_SERROR_ROUTE_OVERRIDE = hyp_view[HC_AMO] ||
                                       route_gen;
    assign VIRT_IRQ_ENABLE = HAS_EL2 && !route_gen;
    assign ILLEGAL_RETURN = INSTR_ERET_TO_EL1 && route_gen;

    assign err_view = (ERROR_RECORD_SELECT == ERRSEL_SHARED) ?
        SHARED_ERR_STATUS : CORE_ERR_STATUS;

    // reads show the stored value, not an overridden one
    assign next_rdata =
        (REG_SEL == SEL_SYN1) ? {32'h0000_0000, syndrome_reg_level1} :
        (REG_SEL == SEL_SYN2) ? {32'h0000_0000, syndrome_reg_level2} :
        (REG_SEL == SEL_SYN3) ? {32'h0000_0000, syndrome_reg_level3} :
        (REG_SEL == SEL_AUXHYP) ? 64'h0000_0000_0000_0000 :
        (REG_SEL == SEL_HYPCFG) ? hyp_view :
        (REG_SEL == SEL_ERRSTAT) ? err_view :
        64'h0000_0000_0000_0000;

    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata <= 64'h0000_0000_0000_0000;
        end else if (CLK_EN && REG_RD) begin
            rdata <= next_rdata;
        end
    end
    assign REG_RDATA = rdata;
endmodule // estc_top

// *** estc_pkg.sv ***
// estc_pkg: field positions, exception classes and access codes for the
// exception syndrome and hypervisor trap control block.
// assumes a single core clock domain; no bus, registers reached by a port.
package estc_pkg;
    // register select codes on the system register access port
    localparam logic [2:0] SEL_SYN1 = 3'h0;
    localparam logic [2:0] SEL_SYN2 = 3'h1;
    localparam logic [2:0] SEL_SYN3 = 3'h2;
    localparam logic [2:0] SEL_AUXHYP = 3'h3;
    localparam logic [2:0] SEL_HYPCFG = 3'h4;
    localparam logic [2:0] SEL_ERRSTAT = 3'h5;
    // syndrome field layout
    localparam int EC_LSB = 26;
    localparam int EC_W = 6;
    localparam int IL_BIT = 25;
    localparam int PAYLOAD_W = 25;
    localparam int EA_BIT = 9;
    localparam int IDS_BIT = 24;
    localparam int AET_LSB = 10;
    localparam int AET_W = 3;
    // exception classes
    localparam logic [5:0] EC_UNKNOWN = 6'h00;
    localparam logic [5:0] EC_PTR_AUTH = 6'h09;
    localparam logic [5:0] EC_SYSREG = 6'h18;
    localparam logic [5:0] EC_INSTR_ABORT_LO = 6'h20;
    localparam logic [5:0] EC_INSTR_ABORT = 6'h21;
    localparam logic [5:0] EC_PC_ALIGN = 6'h22;
    localparam logic [5:0] EC_DATA_ABORT_LO = 6'h24;
    localparam logic [5:0] EC_DATA_ABORT = 6'h25;
    localparam logic [5:0] EC_SP_ALIGN = 6'h26;
    localparam logic [5:0] EC_ILLEGAL_STATE = 6'h0E;
    localparam logic [5:0] EC_SERROR = 6'h2F;
    localparam int ISV_BIT = 24;
    // error type codes
    localparam logic [2:0] AET_UNCONTAINABLE = 3'h0;
    localparam logic [2:0] AET_UNRECOVERABLE = 3'h1;
    // hypervisor configuration fields
    localparam int HC_PTR_AUTH = 41;
    localparam int HC_KEY_TRAP = 40;
    localparam int HC_EXEC_STATE = 31;
    localparam int HC_HYP_CALL_DIS = 29;
    localparam int HC_ROUTE_GEN = 27;
    localparam int HC_ID3_TRAP = 18;
    localparam int HC_HOST_EXT = 34;
    localparam int HC_AMO = 5;
    localparam int HC_IMO = 4;
    localparam int HC_FMO = 3;
    // bits that are reserved zero or reserved one
    localparam logic [63:0] HC_RSVD0_MASK = 64'hFFFF_FC80_2000_0000;
    localparam logic [63:0] HC_RSVD1_MASK = 64'h0000_0000_8000_0000;
    // exception levels and error record select
    localparam logic [1:0] EL0 = 2'h0;
    localparam logic [1:0] EL1 = 2'h1;
    localparam logic [1:0] EL2 = 2'h2;
    localparam logic [1:0] EL3 = 2'h3;
    localparam logic ERRSEL_CORE = 1'b0;
    localparam logic ERRSEL_SHARED = 1'b1;
    // exception kind of a captured event
    typedef enum logic [1:0] {
        EVT_SYNC, EVT_SERR_VIRT, EVT_SERR_PHYS
    } estc_evt_t;
endpackage

// *** estc_syn_fmt.sv ***
// estc_syn_fmt: builds the 32-bit syndrome word for an exception taken.
// assumes the exception source gives class, length, payload and kind.
`timescale 1ns/1ps
module estc_syn_fmt
    import estc_pkg::*;
(
    // event description
    input wire logic [1:0] evt_kind,
    input wire logic [5:0] evt_class,
    input wire logic evt_len32,
    input wire logic [24:0] evt_payload,
    input wire logic evt_aet_unrec,
    input wire logic [24:0] virt_serr_syn,
    // formatted word
    output logic [31:0] syn_word
);
    wire logic force_il;
    wire logic il;
    wire logic [24:0] sync_payload;
    wire logic [24:0] phys_payload;
    wire logic [24:0] payload;
    wire logic is_data_abort;
    wire logic [2:0] error_type_field;

    assign is_data_abort = (evt_class == EC_DATA_ABORT) ||
                           (evt_class == EC_DATA_ABORT_LO);
    // SError kinds, and classes whose length is always reported as 32-bit (data aborts only with ISV clear)
    assign force_il = (evt_kind != EVT_SYNC) ||
                      (evt_class == EC_INSTR_ABORT) ||
                      (evt_class == EC_INSTR_ABORT_LO) ||
                      (evt_class == EC_PC_ALIGN) ||
                      (evt_class == EC_SP_ALIGN) ||
                      (is_data_abort && !evt_payload[ISV_BIT]) ||
                      (evt_class == EC_ILLEGAL_STATE) ||
                      (evt_class == EC_UNKNOWN);
    assign il = force_il ? 1'b1 : evt_len32;
    // external abort bit reads zero on synchronous data aborts
    assign sync_payload = is_data_abort ?
        (evt_payload & ~(25'h1 << EA_BIT)) : evt_payload;
    assign error_type_field = evt_aet_unrec ? AET_UNRECOVERABLE
                               : AET_UNCONTAINABLE;
    assign phys_payload = (evt_payload
        & ~(25'h1 << IDS_BIT) & ~(25'h1 << EA_BIT)
        & ~(25'h7 << AET_LSB)) | {12'h000, error_type_field, 10'h000};
    assign payload = (evt_kind == EVT_SERR_VIRT) ? virt_serr_syn :
                     (evt_kind == EVT_SERR_PHYS) ? phys_payload :
                     sync_payload;
    assign syn_word = {evt_class, il, payload};
endmodule // estc_syn_fmt

// *** estc_chk.sv ***
// estc_chk: port-level assertions for estc_top.
// assumes hyp cfg is written before any trap output or read is relied on.
`timescale 1ns/1ps
module estc_chk
    import estc_pkg::*;
#(
    parameter bit HAS_EL2 = 1'b1
) (
    // clock, reset and register port
    input wire logic CORE_CLK, RESET_N, CLK_EN, REG_RD,
    input wire logic [2:0] REG_SEL,
    input wire logic [63:0] REG_RDATA, CORE_ERR_STATUS, SHARED_ERR_STATUS,
    // core state and decisions
    input wire logic MONITOR_WORLD_SELECT, ERROR_RECORD_SELECT,
    input wire logic STAGE1_MMU_ON_BIT, EFF_STAGE1_MMU_ON, ROUTE_EL1_TO_EL2,
    input wire logic EFF_FIQ_ROUTE_OVERRIDE, EFF_IRQ_ROUTE_OVERRIDE,
    input wire logic EFF_SERROR_ROUTE_OVERRIDE, VIRT_IRQ_ENABLE,
    input wire logic INSTR_ERET_TO_EL1, ILLEGAL_RETURN, TRAP_TO_EL2,
    input wire logic [5:0] TRAP_CLASS
);
default clocking cb @(posedge CORE_CLK); endclocking
default disable iff (!RESET_N);
wire rd_en = REG_RD && CLK_EN;
property p_aux_zero;
    rd_en && REG_SEL == SEL_AUXHYP |=> REG_RDATA == 64'h0;
endproperty
a_aux_zero: assert property (p_aux_zero)
    else $error("aux register read not zero");
property p_rsvd;
    rd_en && REG_SEL == SEL_HYPCFG |=> (REG_RDATA & HC_RSVD0_MASK) == 64'h0
        && REG_RDATA[HC_EXEC_STATE] == HAS_EL2;
endproperty
a_rsvd: assert property (p_rsvd)
    else $error("reserved hyp cfg bits wrong");
property p_errsel;
    rd_en && REG_SEL == SEL_ERRSTAT |=> REG_RDATA == ($past(ERROR_RECORD_SELECT)
        ? $past(SHARED_ERR_STATUS) : $past(CORE_ERR_STATUS));
endproperty
a_errsel: assert property (p_errsel)
    else $error("error record view wrong");
property p_mmu;
    ROUTE_EL1_TO_EL2 |-> !EFF_STAGE1_MMU_ON;
endproperty
a_mmu: assert property (p_mmu)
    else $error("mmu seen on while routed");
property p_ovr;
    ROUTE_EL1_TO_EL2 |-> EFF_FIQ_ROUTE_OVERRIDE && EFF_IRQ_ROUTE_OVERRIDE
        && EFF_SERROR_ROUTE_OVERRIDE && !VIRT_IRQ_ENABLE;
endproperty
a_ovr: assert property (p_ovr)
    else $error("overrides or virtual irq wrong while routed");
property p_secure;
    !MONITOR_WORLD_SELECT |-> !ROUTE_EL1_TO_EL2 && !TRAP_TO_EL2
        && EFF_STAGE1_MMU_ON == STAGE1_MMU_ON_BIT;
endproperty
a_secure: assert property (p_secure)
    else $error("secure world affected by routing");
property p_eret;
    INSTR_ERET_TO_EL1 |-> ILLEGAL_RETURN == ROUTE_EL1_TO_EL2;
endproperty
a_eret: assert property (p_eret)
    else $error("illegal return flag wrong");
property p_cls;
    TRAP_TO_EL2 |-> TRAP_CLASS == EC_PTR_AUTH || TRAP_CLASS == EC_SYSREG;
endproperty
a_cls: assert property (p_cls)
    else $error("trap class wrong");
c_trap: cover property (TRAP_TO_EL2 && TRAP_CLASS == EC_PTR_AUTH);
c_route: cover property (ROUTE_EL1_TO_EL2 && INSTR_ERET_TO_EL1);
c_err: cover property (rd_en && REG_SEL == SEL_ERRSTAT);
endmodule // estc_chk
bind estc_top estc_chk #(.HAS_EL2(HAS_EL2)) u_chk (.*);

// *** estc_top_tb.sv ***
// estc_top_tb: random and corner checks of register access, syndrome
// capture, trap decisions and routing. assumes HAS_EL2 left at 1.
`timescale 1ns/1ps
module estc_top_tb
    import estc_pkg::*;
;
logic CORE_CLK = 0, RESET_N = 0, CLK_EN = 1, REG_WR = 0, REG_RD = 0;
logic [2:0] REG_SEL = '0;
logic [63:0] REG_WDATA = '0, REG_RDATA, CORE_ERR_STATUS = '0;
logic [63:0] SHARED_ERR_STATUS = '0;
logic [1:0] CUR_EL = '0, EXC_TARGET_EL = '0, EXC_KIND = '0;
logic MONITOR_WORLD_SELECT = 0, PTR_AUTH_ENABLED = 0, STAGE1_MMU_ON_BIT = 0;
logic ERROR_RECORD_SELECT = 0, EXC_TAKE = 0, EXC_LEN32 = 0, EXC_AET_UNREC = 0;
logic [24:0] VIRT_SERR_SYN = '0, EXC_PAYLOAD = '0;
logic [5:0] EXC_CLASS = '0, TRAP_CLASS;
logic INSTR_PTR_AUTH = 0, INSTR_KEY_ACCESS = 0, INSTR_ID3_READ = 0;
logic INSTR_ERET_TO_EL1 = 0, TRAP_TO_EL2, ILLEGAL_RETURN, ROUTE_EL1_TO_EL2;
logic EFF_STAGE1_MMU_ON, EFF_FIQ_ROUTE_OVERRIDE, EFF_IRQ_ROUTE_OVERRIDE;
logic EFF_SERROR_ROUTE_OVERRIDE, VIRT_IRQ_ENABLE;
logic [31:0] seed = 32'h5FC4EA20;
int err_total = 0, compares = 0;
localparam logic [5:0] CLS [10] = '{EC_UNKNOWN, EC_ILLEGAL_STATE,
    EC_INSTR_ABORT_LO, EC_INSTR_ABORT, EC_PC_ALIGN, EC_DATA_ABORT_LO,
    EC_DATA_ABORT, EC_SP_ALIGN, EC_PTR_AUTH, EC_SYSREG};
estc_top u_dut (.*);
always #5 CORE_CLK = ~CORE_CLK;
function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
endfunction
function automatic logic [31:0] exp_syn(logic [1:0] k, logic [5:0] c,
        logic l, logic [24:0] p, logic u, logic [24:0] vs);
    logic da;
    da = c == EC_DATA_ABORT_LO || c == EC_DATA_ABORT;
    if (k == 2'h1) return {c, 1'b1, vs};
    if (k == 2'h2) return {c, 2'h2, p[23:13], u ? AET_UNRECOVERABLE
        : AET_UNCONTAINABLE, 1'b0, p[8:0]};
    l = l || c inside {EC_UNKNOWN, EC_ILLEGAL_STATE, EC_INSTR_ABORT_LO,
        EC_INSTR_ABORT, EC_PC_ALIGN, EC_SP_ALIGN} || (da && !p[ISV_BIT]);
    return {c, l, p[24:10], p[9] && !da, p[8:0]};
endfunction
task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
        err_total++;
        $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
endtask
task automatic wr(logic [2:0] s, logic [63:0] d);
    @(posedge CORE_CLK);
    REG_WR <= 1'b1;
    REG_SEL <= s;
    REG_WDATA <= d;
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
endtask
task automatic rd(logic [2:0] s, output logic [63:0] v);
    @(posedge CORE_CLK);
    REG_RD <= 1'b1;
    REG_SEL <= s;
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    #1 v = REG_RDATA;
endtask
task automatic results();
    $display("compares %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
endtask
initial begin
    #200000;
    err_total++;
    results();
end
initial begin
    logic [63:0] v, w, h;
    logic [1:0] k, t;
    logic [5:0] c;
    logic rt, pa, ky, id;
    repeat (4) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    rd(SEL_SYN1, w);
    chk("syn1_reset", w, 64'h0);
    // hyp cfg has no reset value, so it is written before the first trap and routing checks
    for (int i = 0; i < 400; i++) begin
        if (i % 8 == 0) begin
            h = {rnd(), rnd()};
            wr(SEL_HYPCFG, h);
            rd(SEL_HYPCFG, w);
            chk("hyp_config", w, (h & ~HC_RSVD0_MASK) | HC_RSVD1_MASK);
        end
        v = {rnd(), rnd()};
        @(posedge CORE_CLK);
        {CUR_EL, MONITOR_WORLD_SELECT, PTR_AUTH_ENABLED, STAGE1_MMU_ON_BIT,
            INSTR_PTR_AUTH, INSTR_KEY_ACCESS, INSTR_ID3_READ,
            INSTR_ERET_TO_EL1} <= v[8:0];
        #1 rt = h[HC_ROUTE_GEN] && MONITOR_WORLD_SELECT;
        pa = !h[HC_PTR_AUTH] && MONITOR_WORLD_SELECT && INSTR_PTR_AUTH
            && ((CUR_EL == EL0 && (!h[HC_ROUTE_GEN] || !h[HC_HOST_EXT]))
            || (CUR_EL == EL1 && PTR_AUTH_ENABLED));
        ky = !h[HC_KEY_TRAP] && MONITOR_WORLD_SELECT && CUR_EL == EL1
            && INSTR_KEY_ACCESS;
        id = h[HC_ID3_TRAP] && MONITOR_WORLD_SELECT && CUR_EL == EL1
            && INSTR_ID3_READ;
        chk("trap", TRAP_TO_EL2, pa || ky || id);
        if (pa || ky || id) chk("class", TRAP_CLASS, pa ? EC_PTR_AUTH : EC_SYSREG);
        chk("route", ROUTE_EL1_TO_EL2, rt);
        chk("mmu", EFF_STAGE1_MMU_ON, STAGE1_MMU_ON_BIT && !rt);
        chk("fiq", EFF_FIQ_ROUTE_OVERRIDE, h[HC_FMO] || rt);
        chk("irq", EFF_IRQ_ROUTE_OVERRIDE, h[HC_IMO] || rt);
        chk("serr", EFF_SERROR_ROUTE_OVERRIDE, h[HC_AMO] || rt);
        chk("virq", VIRT_IRQ_ENABLE, !rt);
        chk("ill_ret", ILLEGAL_RETURN, INSTR_ERET_TO_EL1 && rt);
    end
    for (int i = 0; i < 200; i++) begin
        v = {rnd(), rnd()};
        k = (v[1:0] == 2'h3) ? 2'h0 : v[1:0];
        t = (v[63:62] == 2'h0) ? EL1 : v[63:62];
        c = (i < 60) ? CLS[i % 10] : v[7:2];
        @(posedge CORE_CLK);
        EXC_TAKE <= 1'b1;
        {EXC_TARGET_EL, EXC_KIND, EXC_CLASS} <= {t, k, c};
        {EXC_LEN32, EXC_PAYLOAD, EXC_AET_UNREC} <= v[36:10];
        VIRT_SERR_SYN <= v[61:37];
        @(posedge CORE_CLK);
        EXC_TAKE <= 1'b0;
        rd({1'b0, t - 2'h1}, w);
        chk("syndrome", w, {32'h0, exp_syn(k, c, v[36], v[35:11], v[10],
            v[61:37])});
    end
    for (int i = 0; i < 8; i++) begin
        v = {rnd(), rnd()};
        @(posedge CORE_CLK);
        CORE_ERR_STATUS <= v;
        SHARED_ERR_STATUS <= ~v;
        ERROR_RECORD_SELECT <= v[0];
        rd(SEL_ERRSTAT, w);
        chk("err_view", w, v[0] ? ~v : v);
        wr(SEL_AUXHYP, v);
        rd(SEL_AUXHYP, w);
        chk("aux_hyp", w, 64'h0);
        rd(3'h6 | {2'h0, v[0]}, w);
        chk("unmapped", w, 64'h0);
    end
    // software write lands, and a write with the clock enable low is lost
    wr(SEL_SYN1, 64'h0000_0000_1234_5678);
    rd(SEL_SYN1, w);
    chk("syn1_wr", w, 64'h0000_0000_1234_5678);
    @(posedge CORE_CLK);
    CLK_EN <= 1'b0;
    wr(SEL_SYN1, 64'h0000_0000_0ABC_DEF0);
    CLK_EN <= 1'b1;
    rd(SEL_SYN1, w);
    chk("syn1_frozen", w, 64'h0000_0000_1234_5678);
    results();
end
endmodule // estc_top_tb
